/* include/rsra_defs.vh */
// Constants for the two-wire register access block of the clock
// Functional notes
// - Answer only own address D0h after START
// - Thirty-two byte locations in fixed order
// - Supply fail aborts, resets pointer, ignores bus
// - START: data falls while clock high
// - STOP: data rises while clock high
// - Data changes only while clock low
// - Eight-bit bytes, ninth bit is acknowledge
// - Acknowledge holds data low through clock high
// - Master not-acknowledge ends read; release data
// - No limit on bytes per transfer
// - Random read: word write, repeated START, read
// - Pointer advances only on acknowledge clock
// - Read continues from consecutive addresses while acknowledged
// - Counters copied to time buffers at START
// - Bare read starts at current pointer
// - Write: word address loads pointer, data follows
// - Acknowledge address, word address, each data byte
// - Load counters at end or past 07h
// - Unwritten time bytes reload their captured values
// - Writes above time range never reload counters
// - Time writes reset divider chain on reload
`ifndef RSRA_DEFS_VH
`define RSRA_DEFS_VH

`define RSRA_SLAVE_ADDR  8'hD0
`define RSRA_PTR_W       5
`define RSRA_PTR_RESET   5'h00
`define RSRA_PTR_STEP    5'h01
`define RSRA_TIME_LAST   5'h07
`define RSRA_TIME_BYTES  8
`define RSRA_BYTE_BITS   4'h8
`define RSRA_LAST_BIT    4'h7
`define RSRA_FIFO_DEPTH  16
`define RSRA_FIFO_AW     4

`endif

/* rtl/rsra_fifo.v */
// Small synchronous FIFO carrying received write bytes with their address
`timescale 1ns/10ps
module rsra_fifo #(
   parameter W  = 13,
   parameter D  = 16,
   parameter AW = 4
) (
   // Clock and reset
   input  wire          clk_in,
   input  wire          rstn_in,
   // Filling side
   input  wire          in_valid_in,
   input  wire [W-1:0]  in_data_in,
   output wire          in_ready_out,
   // Draining side
   output wire          out_valid_out,
   output wire [W-1:0]  out_data_out,
   input  wire          out_ready_in
);

   // Depth must be a power of two; pointers carry one extra wrap bit
   localparam [AW:0] DEPTH = D;

   reg  [W-1:0] mem_q [0:D-1];
   reg  [AW:0]  wp_q;
   reg  [AW:0]  rp_q;
   wire [AW:0]  fill = wp_q - rp_q;
   wire         push = in_valid_in & in_ready_out;
   wire         pop  = out_valid_out & out_ready_in;

   assign in_ready_out  = (fill != DEPTH);
   assign out_valid_out = (fill != {(AW+1){1'b0}});
   assign out_data_out  = mem_q[rp_q[AW-1:0]];

   always @(posedge clk_in) begin
      if (push) begin
         mem_q[wp_q[AW-1:0]] <= in_data_in;
      end
   end

   always @(posedge clk_in) begin
      if (!rstn_in) begin
         wp_q <= {(AW+1){1'b0}};
         rp_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wp_q <= wp_q + {{AW{1'b0}}, 1'b1};
         end
         if (pop) begin
            rp_q <= rp_q + {{AW{1'b0}}, 1'b1};
         end
      end
   end

endmodule // rsra_fifo

/* rtl/rsra_mem.v */
// Byte store for the directly accessed locations, registered read
`timescale 1ns/10ps
module rsra_mem #(
   parameter DW = 8,
   parameter AW = 5
) (
   // Clock and reset
   input  wire          clk_in,
   input  wire          rstn_in,
   // Write port
   input  wire          wr_en_in,
   input  wire [AW-1:0] wr_addr_in,
   input  wire [DW-1:0] wr_data_in,
   // Read port
   input  wire [AW-1:0] rd_addr_in,
   output reg  [DW-1:0] rd_data_out
);

   reg [DW-1:0] mem_q [0:(1<<AW)-1];

   always @(posedge clk_in) begin
      if (wr_en_in) begin
         mem_q[wr_addr_in] <= wr_data_in;
      end
   end

   always @(posedge clk_in) begin
      if (!rstn_in) begin
         rd_data_out <= {DW{1'b0}};
      end else begin
         rd_data_out <= mem_q[rd_addr_in];
      end
   end

endmodule // rsra_mem

/* rtl/rsra_top.v */
// Two-wire slave with pointer, time buffers and coherent counter load
`timescale 1ns/10ps
`include "rsra_defs.vh"
module rsra_top #(
   parameter FIFO_DEPTH = `RSRA_FIFO_DEPTH,
   parameter FIFO_AW    = `RSRA_FIFO_AW
) (
   // Clock and reset
   input  wire        clk_in,
   input  wire        rstn_in,
   // Serial clock pin
   input  wire        scl_in,
   output reg         scl_out_out,
   output reg         scl_oe_out,
   // Serial data pin
   input  wire        sda_in,
   output reg         sda_out_out,
   output reg         sda_oe_out,
   // Supply monitor, high while supply is below supply_trip_level
   input  wire        supply_fail_in,
   // Time counters
   input  wire [63:0] time_count_in,
   output reg         time_load_out,
   output reg  [63:0] time_load_data_out,
   output reg         divider_reset_out
);

   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_RX   = 3'h1;
   localparam [2:0] ST_ACK  = 3'h2;
   localparam [2:0] ST_TX   = 3'h3;
   localparam [2:0] ST_TACK = 3'h4;
   localparam [2:0] ST_IGN  = 3'h5;

   localparam [1:0] PH_ADDR = 2'h0;
   localparam [1:0] PH_WORD = 2'h1;
   localparam [1:0] PH_DATA = 2'h2;

   localparam PW = `RSRA_PTR_W;
   localparam FW = PW + 8;

   function is_time_addr;
      input [PW-1:0] a;
      begin
         is_time_addr = (a <= `RSRA_TIME_LAST);
      end
   endfunction

   // Pointer step shared by read and write acknowledges; wraps 31 to 0
   function [PW-1:0] next_ptr;
      input [PW-1:0] a;
      begin
         next_ptr = a + `RSRA_PTR_STEP;
      end
   endfunction

   // Pin synchronisers; only the second stage and later are read
   reg scl_m_q;
   reg scl_s_q;
   reg scl_p_q;
   reg sda_m_q;
   reg sda_s_q;
   reg sda_p_q;
   reg pf_m_q;
   reg pf_s_q;

   always @(posedge clk_in) begin
      if (!rstn_in) begin
         scl_m_q <= 1'b1;
         scl_s_q <= 1'b1;
         scl_p_q <= 1'b1;
         sda_m_q <= 1'b1;
         sda_s_q <= 1'b1;
         sda_p_q <= 1'b1;
         pf_m_q  <= 1'b0;
         pf_s_q  <= 1'b0;
      end else begin
         scl_m_q <= scl_in;
         scl_s_q <= scl_m_q;
         scl_p_q <= scl_s_q;
         sda_m_q <= sda_in;
         sda_s_q <= sda_m_q;
         sda_p_q <= sda_s_q;
         pf_m_q  <= supply_fail_in;
         pf_s_q  <= pf_m_q;
      end
   end

   wire scl_rise = scl_s_q & ~scl_p_q;
   wire scl_fall = ~scl_s_q & scl_p_q;
   // Data edges only count while the clock stays high on both samples
   wire start_c  = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
   wire stop_c   = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

   reg  [2:0]    state_q;
   reg  [1:0]    phase_q;
   reg  [3:0]    cnt_q;
   reg  [7:0]    shift_q;
   reg  [7:0]    tx_q;
   reg  [PW-1:0] ptr_q;
   reg           rw_q;
   reg           nak_q;
   reg           pushed_q;
   reg           tw_q;
   reg           load_pend_q;
   reg           cap_pend_q;
   reg  [7:0]    buf_q [0:`RSRA_TIME_BYTES-1];

   wire [7:0]    mem_rd;
   wire          fifo_in_ready;
   wire          fifo_out_valid;
   wire [FW-1:0] fifo_out_data;

   wire [PW-1:0] drain_addr = fifo_out_data[FW-1:8];
   wire [7:0]    drain_data = fifo_out_data[7:0];
   // Capture waits for a pending reload, and the drain yields for that one cycle
   wire          cap_now    = cap_pend_q & ~load_pend_q;
   wire          drain_rdy  = ~cap_now;
   wire          drain_fire = fifo_out_valid & drain_rdy;
   wire          push       = (state_q == ST_ACK) & (phase_q == PH_DATA) & ~pushed_q
                              & fifo_in_ready;
   wire          mem_we     = drain_fire & ~is_time_addr(drain_addr);
   // Locations 0-7 read from the buffers, never from the counters
   wire [7:0]    rd_byte    = is_time_addr(ptr_q) ? buf_q[ptr_q[2:0]] : mem_rd;

   integer i;

   always @(posedge clk_in) begin
      if (!rstn_in) begin
         state_q            <= ST_IDLE;
         phase_q            <= PH_ADDR;
         cnt_q              <= 4'h0;
         shift_q            <= 8'h00;
         tx_q               <= 8'h00;
         ptr_q              <= `RSRA_PTR_RESET;
         rw_q               <= 1'b0;
         nak_q              <= 1'b0;
         pushed_q           <= 1'b1;
         tw_q               <= 1'b0;
         load_pend_q        <= 1'b0;
         cap_pend_q         <= 1'b0;
         sda_oe_out         <= 1'b0;
         sda_out_out        <= 1'b0;
         scl_oe_out         <= 1'b0;
         scl_out_out        <= 1'b0;
         time_load_out      <= 1'b0;
         divider_reset_out  <= 1'b0;
         time_load_data_out <= 64'h0000000000000000;
         for (i = 0; i < `RSRA_TIME_BYTES; i = i + 1) begin
            buf_q[i] <= 8'h00;
         end
      end else begin
         time_load_out     <= 1'b0;
         divider_reset_out <= 1'b0;

         // Buffer side: reload once the store is drained, then capture, else drain writes
         if (load_pend_q && !fifo_out_valid) begin
            // All eight bytes go back, unwritten ones as captured
            for (i = 0; i < `RSRA_TIME_BYTES; i = i + 1) begin
               time_load_data_out[8*i +: 8] <= buf_q[i];
            end
            time_load_out     <= 1'b1;
            divider_reset_out <= 1'b1;
            load_pend_q       <= 1'b0;
         end else if (cap_now) begin
            for (i = 0; i < `RSRA_TIME_BYTES; i = i + 1) begin
               buf_q[i] <= time_count_in[8*i +: 8];
            end
            cap_pend_q <= 1'b0;
         end else if (drain_fire && is_time_addr(drain_addr)) begin
            buf_q[drain_addr[2:0]] <= drain_data;
         end

         // Bus side
         if (pf_s_q) begin
            // Abort, park the pointer and stay deaf while supply is low
            state_q    <= ST_IDLE;
            ptr_q      <= `RSRA_PTR_RESET;
            sda_oe_out <= 1'b0;
            scl_oe_out <= 1'b0;
            pushed_q   <= 1'b1;
            tw_q       <= 1'b0;
         end else if (start_c) begin
            state_q    <= ST_RX;
            phase_q    <= PH_ADDR;
            cnt_q      <= 4'h0;
            sda_oe_out <= 1'b0;
            scl_oe_out <= 1'b0;
            pushed_q   <= 1'b1;
            cap_pend_q <= 1'b1;
            // A repeated START also ends a write transfer
            if (tw_q) begin
               load_pend_q <= 1'b1;
            end
            tw_q <= 1'b0;
         end else if (stop_c) begin
            state_q    <= ST_IDLE;
            sda_oe_out <= 1'b0;
            scl_oe_out <= 1'b0;
            pushed_q   <= 1'b1;
            // Only a transfer that touched 0-7 reloads the counters
            if (tw_q) begin
               load_pend_q <= 1'b1;
            end
            tw_q <= 1'b0;
         end else begin
            case (state_q)
               ST_RX: begin
                  // Sample on the rising clock, line is stable while high
                  if (scl_rise) begin
                     shift_q <= {shift_q[6:0], sda_s_q};
                     cnt_q   <= cnt_q + 4'h1;
                  end else if (scl_fall && cnt_q == `RSRA_BYTE_BITS) begin
                     cnt_q <= 4'h0;
                     case (phase_q)
                        PH_ADDR: begin
                           if ({shift_q[7:1], 1'b0} == `RSRA_SLAVE_ADDR) begin
                              // Direction bit picks transmit or receive after the ack
                              rw_q       <= shift_q[0];
                              sda_oe_out <= 1'b1;
                              state_q    <= ST_ACK;
                           end else begin
                              state_q <= ST_IGN;
                           end
                        end
                        PH_WORD: begin
                           ptr_q      <= shift_q[PW-1:0];
                           sda_oe_out <= 1'b1;
                           state_q    <= ST_ACK;
                        end
                        default: begin
                           pushed_q   <= 1'b0;
                           sda_oe_out <= 1'b1;
                           state_q    <= ST_ACK;
                        end
                     endcase
                  end
               end
               ST_ACK: begin
                  // Received data waits here; clock stretched if the store is full
                  // Assigned every cycle so the stretch always lets go once pushed
                  scl_oe_out <= (phase_q == PH_DATA) & ~pushed_q & ~fifo_in_ready;
                  if (push) begin
                     pushed_q <= 1'b1;
                     // A time byte in the store marks the transfer for reload
                     if (is_time_addr(ptr_q)) begin
                        tw_q <= 1'b1;
                     end
                  end
                  if (scl_rise && phase_q == PH_DATA) begin
                     ptr_q <= next_ptr(ptr_q);
                     // Leaving 07h after a time write reloads early
                     if (ptr_q == `RSRA_TIME_LAST && tw_q) begin
                        load_pend_q <= 1'b1;
                        tw_q        <= 1'b0;
                     end
                  end
                  if (scl_fall) begin
                     // Ack held low through the whole high phase
                     sda_oe_out <= 1'b0;
                     cnt_q      <= 4'h0;
                     if (phase_q == PH_ADDR && rw_q) begin
                        // Reading from wherever the pointer stands
                        tx_q       <= rd_byte;
                        sda_oe_out <= ~rd_byte[7];
                        state_q    <= ST_TX;
                     end else begin
                        phase_q <= (phase_q == PH_ADDR) ? PH_WORD : PH_DATA;
                        state_q <= ST_RX;
                     end
                  end
               end
               ST_TX: begin
                  // Drive changes only after the clock has gone low
                  if (scl_fall) begin
                     if (cnt_q == `RSRA_LAST_BIT) begin
                        sda_oe_out <= 1'b0;
                        state_q    <= ST_TACK;
                     end else begin
                        tx_q       <= {tx_q[6:0], 1'b0};
                        sda_oe_out <= ~tx_q[6];
                        cnt_q      <= cnt_q + 4'h1;
                     end
                  end
               end
               ST_TACK: begin
                  // Master's ninth bit decides whether another byte follows
                  if (scl_rise) begin
                     ptr_q <= next_ptr(ptr_q);
                     nak_q <= sda_s_q;
                  end
                  if (scl_fall) begin
                     cnt_q <= 4'h0;
                     if (nak_q) begin
                        // Line stays released so the master can STOP
                        state_q <= ST_IGN;
                     end else begin
                        tx_q       <= rd_byte;
                        sda_oe_out <= ~rd_byte[7];
                        state_q    <= ST_TX;
                     end
                  end
               end
               ST_IGN: begin
                  // Off the bus until the next START or STOP
                  sda_oe_out <= 1'b0;
                  scl_oe_out <= 1'b0;
               end
               default: begin
                  state_q <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // Received bytes queue here while a capture holds the buffers
   rsra_fifo #(
      .W  (FW),
      .D  (FIFO_DEPTH),
      .AW (FIFO_AW)
   ) u_fifo (
      .clk_in        (clk_in),
      .rstn_in       (rstn_in),
      .in_valid_in   (push),
      .in_data_in    ({ptr_q, shift_q}),
      .in_ready_out  (fifo_in_ready),
      .out_valid_out (fifo_out_valid),
      .out_data_out  (fifo_out_data),
      .out_ready_in  (drain_rdy)
   );

   // Thirty-two locations; 0-7 are shadowed by the time buffers
   rsra_mem #(
      .DW (8),
      .AW (PW)
   ) u_mem (
      .clk_in      (clk_in),
      .rstn_in     (rstn_in),
      .wr_en_in    (mem_we),
      .wr_addr_in  (drain_addr),
      .wr_data_in  (drain_data),
      .rd_addr_in  (ptr_q),
      .rd_data_out (mem_rd)
   );

endmodule // rsra_top

/* sim/rsra_checker.sv */
// Pin-level protocol and counter-load checks for the clock register block
`timescale 1ns/10ps
module rsra_checker (
   // Clock and reset
   input wire        clk_in,
   input wire        rstn_in,
   // Serial pins
   input wire        scl_in,
   input wire        scl_out_out,
   input wire        scl_oe_out,
   input wire        sda_in,
   input wire        sda_out_out,
   input wire        sda_oe_out,
   // Supply and counters
   input wire        supply_fail_in,
   input wire [63:0] time_count_in,
   input wire        time_load_out,
   input wire [63:0] time_load_data_out,
   input wire        divider_reset_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   logic scl_q;
   logic sda_q;
   wire  stop_ev = scl_q && scl_in && !sda_q && sda_in;

   always @(posedge clk_in) begin
      scl_q <= scl_in;
      sda_q <= sda_in;
   end

   load_div_a: assert property (time_load_out |-> divider_reset_out)
      else $error("Divider reset missing at counter load");
   div_load_a: assert property (divider_reset_out |-> time_load_out)
      else $error("Divider reset without counter load");
   load_pulse_a: assert property (time_load_out |=> !time_load_out[*3])
      else $error("Counter load longer than one cycle");
   load_hold_a: assert property (time_load_out |=> $stable(time_load_data_out))
      else $error("Load data moved right after the load");
   drive_low_a: assert property (!scl_out_out && !sda_out_out)
      else $error("Open-drain pin driven high");
   hold_high_a: assert property ((scl_in && !supply_fail_in)[*4] |-> $stable(sda_oe_out))
      else $error("Data pin changed while clock high");
   fail_quiet_a: assert property (supply_fail_in[*6] |-> !sda_oe_out && !scl_oe_out && !time_load_out)
      else $error("Bus activity during supply failure");
   stop_rel_a: assert property (stop_ev |-> ##5 !sda_oe_out)
      else $error("Data pin held after stop");

   cover property (time_load_out);
   cover property ($rose(sda_oe_out));
   cover property (stop_ev);
endmodule // rsra_checker

/* sim/rsra_master.sv */
// Two-wire bus master model driving the clock block's serial pins
`timescale 1ns/10ps
module rsra_master (
   // Wire levels
   input  wire  scl_in,
   input  wire  sda_in,
   // Open-drain pull-downs
   output logic scl_low_out,
   output logic sda_low_out
);
   initial begin
      scl_low_out = 1'b0;
      sda_low_out = 1'b0;
   end
   int n_stall = 0;
   // The slave may stretch the low phase; give up after 10 us and count it
   task automatic wait_high;
      for (int i = 0; i < 400 && scl_in !== 1'b1; i++) #25;
      if (scl_in !== 1'b1) n_stall++;
   endtask
   // From idle, or as a repeated start from a low clock
   task automatic start;
      sda_low_out = 1'b0;
      #50 scl_low_out = 1'b0;
      wait_high;
      #50 sda_low_out = 1'b1;
      #50 scl_low_out = 1'b1;
      #50;
   endtask
   task automatic stop;
      sda_low_out = 1'b1;
      #50 scl_low_out = 1'b0;
      wait_high;
      #50 sda_low_out = 1'b0;
      #50;
   endtask
   // Data set mid-low, sampled mid-high
   task automatic xbit(input logic b, output logic r);
      sda_low_out = !b;
      #50 scl_low_out = 1'b0;
      wait_high;
      #50 r = sda_in;
      #50 scl_low_out = 1'b1;
      #50;
   endtask
   // Ninth bit released on writes, master acknowledge or not on reads
   task automatic xbyte(input logic [7:0] d, input logic nine, output logic [7:0] q,
                        output logic r9);
      for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
      xbit(nine, r9);
   endtask
endmodule // rsra_master

/* sim/rtc_serial_register_access_test.sv */
// Self-checking bench for the two-wire clock register block
`timescale 1ns/10ps
module rtc_serial_register_access_test;
   localparam logic [63:0] TC1 = 64'h8877665544332211;
   localparam logic [63:0] TC2 = 64'h0F1E2D3C4B5A6978;
   logic        clk_in = 1'b0;
   logic        rstn_in = 1'b0;
   logic        supply_fail_in = 1'b0;
   logic [63:0] time_count_in = TC1;
   logic [63:0] load_data_q = 64'h0;
   int          n_load = 0;
   int          n_mismatch = 0;
   int          n_checks = 0;
   wire         scl_oe_out, sda_oe_out, time_load_out, divider_reset_out;
   wire [63:0]  time_load_data_out;
   wire         m_scl_low, m_sda_low;
   // Pull-ups: a line is high unless some party pulls it down
   wire         scl_line = !(m_scl_low || scl_oe_out);
   wire         sda_line = !(m_sda_low || sda_oe_out);

   always #12.5 clk_in = !clk_in;

   rsra_top i_dut (.clk_in(clk_in), .rstn_in(rstn_in), .scl_in(scl_line), .scl_out_out(),
      .scl_oe_out(scl_oe_out), .sda_in(sda_line), .sda_out_out(), .sda_oe_out(sda_oe_out),
      .supply_fail_in(supply_fail_in), .time_count_in(time_count_in),
      .time_load_out(time_load_out), .time_load_data_out(time_load_data_out),
      .divider_reset_out(divider_reset_out));
   rsra_master i_mst (.scl_in(scl_line), .sda_in(sda_line), .scl_low_out(m_scl_low),
      .sda_low_out(m_sda_low));

   always @(posedge clk_in) begin
      if (time_load_out === 1'b1) begin
         n_load <= n_load + 1;
         load_data_q <= time_load_data_out;
      end
   end

   // Shared reporter behind the typed compares below
   task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_ack(input logic got, input logic exp);
      cmp({63'h0, got}, {63'h0, exp});
   endtask
   task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
      cmp({56'h0, got}, {56'h0, exp});
   endtask
   task automatic cmp_count(input logic [31:0] got, input logic [31:0] exp);
      cmp({32'h0, got}, {32'h0, exp});
   endtask
   task automatic cmp_load(input logic [63:0] got, input logic [63:0] exp);
      cmp(got, exp);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #2;
   endtask
   // Sends n bytes, first byte in the top of the used range
   task automatic wr(input logic [63:0] b, input int n, input logic ack, input logic stp);
      logic [7:0] q;
      logic       r9;
      i_mst.start();
      for (int i = 0; i < n; i++) begin
         i_mst.xbyte(b[8*(n-1-i) +: 8], 1'b1, q, r9);
         cmp_ack(~r9, ack);
      end
      if (stp) i_mst.stop();
   endtask
   task automatic rd(input logic [63:0] e, input int n);
      logic [7:0] q;
      logic       r9;
      i_mst.start();
      i_mst.xbyte(8'hD1, 1'b1, q, r9);
      cmp_ack(~r9, 1'b1);
      for (int i = 0; i < n; i++) begin
         i_mst.xbyte(8'hFF, i == n - 1, q, r9);
         cmp_byte(q, e[8*(n-1-i) +: 8]);
      end
      i_mst.stop();
   endtask
   task automatic wait_load(input int exp);
      for (int i = 0; i < 40 && n_load != exp; i++) tick(1);
      cmp_count(n_load, exp);
   endtask

   task automatic sc_write_time;
      int b;
      b = n_load;
      wr(64'hD0015B, 3, 1'b1, 1'b1);
      wait_load(b + 1);
      cmp_load(load_data_q, {TC1[63:16], 8'h5B, TC1[7:0]});
   endtask
   task automatic sc_rand_read;
      time_count_in = TC2;
      wr(64'hD002, 2, 1'b1, 1'b0);
      rd({TC2[23:16], TC2[31:24], TC2[39:32]}, 3);
   endtask
   task automatic sc_high_write;
      int b;
      b = n_load;
      wr(64'hD01E5AC3, 4, 1'b1, 1'b1);
      tick(40);
      cmp_count(n_load, b);
      rd({TC2[7:0], TC2[15:8]}, 2);
      wr(64'hD01E, 2, 1'b1, 1'b0);
      rd({8'h5A, 8'hC3, TC2[7:0]}, 3);
   endtask
   task automatic sc_past_seven;
      int b;
      b = n_load;
      wr(64'hD0079944, 4, 1'b1, 1'b0);
      wait_load(b + 1);
      cmp_load(load_data_q, {8'h99, TC2[55:0]});
      i_mst.stop();
      tick(40);
      cmp_count(n_load, b + 1);
   endtask
   task automatic sc_foreign;
      wr(64'hA001, 2, 1'b0, 1'b1);
   endtask
   task automatic sc_supply;
      int         b;
      logic [7:0] q;
      logic       r9;
      b = n_load;
      i_mst.start();
      i_mst.xbyte(8'hD0, 1'b1, q, r9);
      cmp_ack(~r9, 1'b1);
      i_mst.xbyte(8'h03, 1'b1, q, r9);
      cmp_ack(~r9, 1'b1);
      supply_fail_in = 1'b1;
      i_mst.xbyte(8'h55, 1'b1, q, r9);
      cmp_ack(~r9, 1'b0);
      supply_fail_in = 1'b0;
      i_mst.stop();
      tick(40);
      cmp_count(n_load, b);
      rd({56'h0, TC2[7:0]}, 1);
   endtask

   // Single exit point for both the normal end and a hang
   task automatic finish_test;
      // A clock that never came back high is a hang in the link
      n_mismatch += i_mst.n_stall;
      $display("Comparisons %0d, mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial begin
      tick(20);
      rstn_in = 1'b1;
      tick(3);
      sc_write_time;
      sc_rand_read;
      sc_high_write;
      sc_past_seven;
      sc_foreign;
      sc_supply;
      finish_test;
   end
   initial begin
      #1000000;
      n_mismatch++;
      finish_test;
   end
endmodule // rtc_serial_register_access_test

bind rsra_top rsra_checker i_chk (.clk_in(clk_in), .rstn_in(rstn_in), .scl_in(scl_in),
   .scl_out_out(scl_out_out), .scl_oe_out(scl_oe_out), .sda_in(sda_in),
   .sda_out_out(sda_out_out), .sda_oe_out(sda_oe_out), .supply_fail_in(supply_fail_in),
   .time_count_in(time_count_in), .time_load_out(time_load_out),
   .time_load_data_out(time_load_data_out), .divider_reset_out(divider_reset_out));
